// *** rtl/subdp_pkg.sv ***
// package: opcode fields, flag positions and reset values for the subtract datapath
package subdp_pkg;
    localparam int          INSTR_W        = 16;
    localparam int          INSTR_MSB      = 15;
    localparam int          LIT_HI_LSB     = 8;      // literal opcode byte starts here
    localparam int          FILE_HI_LSB    = 10;     // file opcode field starts here
    localparam int          OPD_MSB        = 7;      // literal or file address byte
    localparam logic [7:0]  OPC_LIT_HI     = 8'h08;   // literal subtract upper byte
    localparam logic [5:0]  OPC_FILE_HI    = 6'h17;   // file subtract bits 15:10
    localparam int          D_BIT          = 9;
    localparam int          A_BIT          = 8;
    localparam logic [7:0]  ACC_RST        = 8'h00;
    localparam logic [3:0]  BSR_RST        = 4'h0;
    localparam logic [3:0]  ACCESS_BANK    = 4'h0;    // access bank page
    localparam logic [4:0]  FLAGS_RST      = 5'h00;
    localparam logic [7:0]  ZERO_BYTE      = 8'h00;
    // flag positions within the status vector
    localparam int          FLG_C          = 0;
    localparam int          FLG_DC         = 1;
    localparam int          FLG_Z          = 2;
    localparam int          FLG_OV         = 3;
    localparam int          FLG_N          = 4;
    localparam int          SIGN_BIT       = 7;
    localparam int          NIB_BIT        = 4;
    localparam int          CARRY_BIT      = 8;
endpackage

// *** rtl/subdp_core.sv ***
// subtract instruction datapath: decode, operand fetch, result writeback, flags
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
//
// The address map and the address-and-strobe port are this design's own decisions.
module subdp_core
    import subdp_pkg::*;
(
    input  wire logic               i_mclk,
    input  wire logic               i_rst,
    input  wire logic               i_instr_valid,
    input  wire logic [INSTR_W-1:0] i_instr,
    input  wire logic [7:0]         i_file_rdata,
    input  wire logic               i_bsr_we,
    input  wire logic [3:0]         i_bsr_wdata,
    output logic      [11:0]        o_file_addr,
    output logic                    o_file_we,
    output logic      [7:0]         o_file_wdata,
    output logic      [7:0]         o_acc,
    output logic      [3:0]         o_bank_select_register,
    output logic      [4:0]         o_flags
);
    logic [7:0] acc_reg;
    logic [3:0] bsr_reg;
    logic [4:0] flags_reg;
    logic       file_we_reg;
    logic [7:0] file_wdata_reg;
    logic       is_lit;
    logic       is_file;
    logic [7:0] minuend;
    logic [8:0] diff;
    logic [4:0] nib;
    logic [7:0] res;
    logic [4:0] flags_next;

    //////////////////////////////////////////////////////////////////////////
    // decode
    assign is_lit  = i_instr_valid &&
                     (i_instr[INSTR_MSB:LIT_HI_LSB] == OPC_LIT_HI);
    assign is_file = i_instr_valid &&
                     (i_instr[INSTR_MSB:FILE_HI_LSB] == OPC_FILE_HI);

    // data address: bank page plus 8-bit file address
    assign o_file_addr = {(i_instr[A_BIT] ? bsr_reg : ACCESS_BANK),
                          i_instr[OPD_MSB:0]};

    // arithmetic: minuend minus accumulator
    assign minuend = is_lit ? i_instr[OPD_MSB:0] : i_file_rdata;
    assign diff    = {1'b0, minuend} - {1'b0, acc_reg};
    assign nib     = {1'b0, minuend[3:0]} - {1'b0, acc_reg[3:0]};
    assign res     = diff[7:0];

    // flag computation; carry means no borrow
    always_comb begin
        flags_next          = flags_reg;
        flags_next[FLG_C]   = ~diff[CARRY_BIT];
        flags_next[FLG_DC]  = ~nib[NIB_BIT];
        flags_next[FLG_Z]   = (res == ZERO_BYTE);
        flags_next[FLG_N]   = res[SIGN_BIT];
        flags_next[FLG_OV]  = (minuend[SIGN_BIT] != acc_reg[SIGN_BIT]) &&
                              (res[SIGN_BIT] != minuend[SIGN_BIT]);
    end

    //////////////////////////////////////////////////////////////////////////
    // accumulator writeback
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            acc_reg <= ACC_RST;
        end else if (is_lit || (is_file && !i_instr[D_BIT])) begin
            acc_reg <= res;
        end
    end

    // file register writeback strobe
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            file_we_reg    <= 1'b0;
            file_wdata_reg <= ZERO_BYTE;
        end else begin
            file_we_reg    <= is_file && i_instr[D_BIT];
            file_wdata_reg <= res;
        end
    end

    // status flags
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            flags_reg <= FLAGS_RST;
        end else if (is_lit || is_file) begin
            flags_reg <= flags_next;
        end
    end

    // bank select register
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            bsr_reg <= BSR_RST;
        end else if (i_bsr_we) begin
            bsr_reg <= i_bsr_wdata;
        end
    end

    assign o_acc                  = acc_reg;
    assign o_flags                = flags_reg;
    assign o_file_we              = file_we_reg;
    assign o_file_wdata           = file_wdata_reg;
    assign o_bank_select_register = bsr_reg;

    //////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_lit_issue;
        is_lit;
    endsequence

    // either subtract taken this cycle
    sequence s_any_sub;
        is_lit || is_file;
    endsequence

    // file subtract that writes the file byte
    sequence s_file_to_file;
        is_file && i_instr[D_BIT];
    endsequence

    // sign-extended difference, overflow when bits 8 and 7 disagree
    logic [8:0] chk_sdiff;
    assign chk_sdiff = {minuend[SIGN_BIT], minuend} - {acc_reg[SIGN_BIT], acc_reg};

    // overflow flag against a wider signed difference
    AST_OV: assert property (@(posedge i_mclk) disable iff (i_rst)
        s_any_sub |=> o_flags[FLG_OV] == $past(chk_sdiff[CARRY_BIT] ^ chk_sdiff[SIGN_BIT]))
        else $error("overflow flag wrong");

    // digit carry set when the low nibble needs no borrow
    AST_DC: assert property (@(posedge i_mclk) disable iff (i_rst)
        s_any_sub |=> o_flags[FLG_DC] ==
        $past(minuend[NIB_BIT-1:0] >= acc_reg[NIB_BIT-1:0]))
        else $error("digit carry flag wrong");

    // carry set when the whole byte needs no borrow
    AST_CARRY: assert property (@(posedge i_mclk) disable iff (i_rst)
        s_any_sub |=> o_flags[FLG_C] == $past(minuend >= acc_reg))
        else $error("carry flag wrong");

    // other words leave accumulator and flags untouched
    AST_HOLD: assert property (@(posedge i_mclk) disable iff (i_rst)
        !(is_lit || is_file) |=> $stable(o_acc) && $stable(o_flags))
        else $error("state changed without subtract");

    // writeback strobe only after a file-destination subtract
    AST_NO_WB: assert property (@(posedge i_mclk) disable iff (i_rst)
        !(is_file && i_instr[D_BIT]) |=> !o_file_we)
        else $error("file write without file destination");

    // a file-destination subtract gives a one-cycle strobe
    AST_WB_PULSE: assert property (@(posedge i_mclk) disable iff (i_rst)
        s_file_to_file ##1 !(is_file && i_instr[D_BIT]) |=> !o_file_we)
        else $error("writeback strobe too long");

    // bank select register takes the loaded value
    AST_BANK_LOAD: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_bsr_we |=> o_bank_select_register == $past(i_bsr_wdata))
        else $error("bank select load wrong");

    AST_LIT_ACC: assert property (@(posedge i_mclk) disable iff (i_rst)
        s_lit_issue |=> o_acc == $past(i_instr[OPD_MSB:0]) - $past(acc_reg))
        else $error("literal subtract result wrong");

    AST_FILE_DEST_F: assert property (@(posedge i_mclk) disable iff (i_rst)
        s_file_to_file |=> o_file_we &&
        o_file_wdata == $past(i_file_rdata) - $past(acc_reg) && $stable(o_acc))
        else $error("file subtract to file wrong");

    AST_FILE_DEST_W: assert property (@(posedge i_mclk) disable iff (i_rst)
        (is_file && !i_instr[D_BIT]) |=> !o_file_we &&
        o_acc == $past(i_file_rdata) - $past(acc_reg))
        else $error("file subtract to accumulator wrong");

    AST_BANKED: assert property (@(posedge i_mclk) disable iff (i_rst)
        (is_file && i_instr[A_BIT]) |-> o_file_addr[11:8] == bsr_reg)
        else $error("banked address wrong");

    AST_ACCESS: assert property (@(posedge i_mclk) disable iff (i_rst)
        (is_file && !i_instr[A_BIT]) |-> o_file_addr[11:8] == ACCESS_BANK)
        else $error("access bank address wrong");

    AST_ADDR: assert property (@(posedge i_mclk) disable iff (i_rst)
        is_file |-> o_file_addr[OPD_MSB:0] == i_instr[OPD_MSB:0])
        else $error("file address wrong");

    AST_ZERO: assert property (@(posedge i_mclk) disable iff (i_rst)
        ((is_lit || is_file) && minuend == acc_reg) |=>
        o_flags[FLG_Z] && o_flags[FLG_C] && !o_flags[FLG_N])
        else $error("zero result flags wrong");

    AST_BORROW: assert property (@(posedge i_mclk) disable iff (i_rst)
        ((is_lit || is_file) && minuend < acc_reg) |=>
        !o_flags[FLG_C] && !o_flags[FLG_Z])
        else $error("borrow flags wrong");

    AST_NEG: assert property (@(posedge i_mclk) disable iff (i_rst)
        (is_lit || is_file) |=> o_flags[FLG_N] == $past(res[SIGN_BIT]))
        else $error("negative flag wrong");
endmodule

// *** verification/subdp_tb_top.sv ***
// self-checking bench for the subtract datapath with a reference model
module subtract_instruction_datapath_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import subdp_pkg::*;
    logic i_mclk, i_rst, i_instr_valid, i_bsr_we, e_we;
    logic [15:0] i_instr;
    logic [7:0] i_file_rdata, m_acc, e_wd, o_file_wdata, o_acc;
    logic [3:0] i_bsr_wdata, m_bsr, o_bank_select_register;
    logic [4:0] m_flg, o_flags;
    logic [11:0] o_file_addr;
    logic o_file_we;
    int n_fail, num_checks;
    subdp_core u_subdp_core (.i_mclk(i_mclk), .i_rst(i_rst), .i_instr_valid(i_instr_valid),
        .i_instr(i_instr), .i_file_rdata(i_file_rdata), .i_bsr_we(i_bsr_we),
        .i_bsr_wdata(i_bsr_wdata), .o_file_addr(o_file_addr), .o_file_we(o_file_we),
        .o_file_wdata(o_file_wdata), .o_acc(o_acc),
        .o_bank_select_register(o_bank_select_register), .o_flags(o_flags));
    // 100 ns clock
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    // compare and count
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // difference and flags {n, ov, z, dc, c}, carries mean no borrow
    function automatic logic [12:0] sub(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] r;
        r = a - b;
        return {r[7], (a[7] != b[7]) && (r[7] != a[7]), r == 8'h00,
                a[3:0] >= b[3:0], a >= b, r};
    endfunction
    // results of the previous instruction, visible one cycle later
    task automatic post();
        check(12'(o_acc), 12'(m_acc));
        check(12'(o_flags), 12'(m_flg));
        check(12'(o_file_we), 12'(e_we));
        if (e_we) check(12'(o_file_wdata), 12'(e_wd));
        check(12'(o_bank_select_register), 12'(m_bsr));
    endtask
    // one instruction cycle, back to back with the next
    task automatic op(input logic [15:0] ins, input logic [7:0] rd, input logic bw,
                      input logic [3:0] bd);
        logic [12:0] r;
        logic lit, fil;
        @(posedge i_mclk);
        i_instr <= ins;
        i_instr_valid <= 1'b1;
        i_file_rdata <= rd;
        i_bsr_we <= bw;
        i_bsr_wdata <= bd;
        #1;
        post();
        lit = ins[15:8] == OPC_LIT_HI;
        fil = ins[15:10] == OPC_FILE_HI;
        if (fil) check(o_file_addr, {ins[A_BIT] ? m_bsr : ACCESS_BANK, ins[7:0]});
        r = sub(fil ? rd : ins[7:0], m_acc);
        e_we = fil & ins[D_BIT];
        e_wd = r[7:0];
        if (lit | fil) m_flg = r[12:8];
        if (lit | (fil & !ins[D_BIT])) m_acc = r[7:0];
        if (bw) m_bsr = bd;
    endtask
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        {i_rst, i_instr_valid, i_bsr_we, i_instr, i_file_rdata, i_bsr_wdata} = '0;
        i_rst = 1'b1;
        {m_acc, m_flg, m_bsr, e_we, e_wd} = '0;
        void'($urandom(32'hde8d61c9));
        repeat (4) @(posedge i_mclk);
        i_rst <= 1'b0;
        // corners: zero result, negative file writeback, banked address, ignored word
        op(16'h0803, 8'h00, 1'b1, 4'ha);
        op(16'h0803, 8'h00, 1'b0, 4'h0);
        op(16'h5d7f, 8'h05, 1'b0, 4'h0);
        op(16'h5e00, 8'h04, 1'b0, 4'h0);
        op(16'h5fff, 8'h80, 1'b0, 4'h0);
        op(16'h0000, 8'h11, 1'b0, 4'h0);
        repeat (400) begin
            case ($urandom % 3)
                0: op({OPC_LIT_HI, 8'($urandom)}, 8'($urandom), 1'($urandom), 4'($urandom));
                1: op({OPC_FILE_HI, 10'($urandom)}, 8'($urandom), 1'($urandom), 4'($urandom));
                default: op(16'($urandom), 8'($urandom), 1'($urandom), 4'($urandom));
            endcase
        end
        @(posedge i_mclk);
        i_instr_valid <= 1'b0;
        i_bsr_we <= 1'b0;
        #1;
        post();
        // mid-run reset clears accumulator, flags and bank page
        @(posedge i_mclk);
        i_rst <= 1'b1;
        @(posedge i_mclk);
        i_rst <= 1'b0;
        #1;
        {m_acc, m_flg, m_bsr, e_we} = '0;
        post();
        op(16'h0802, 8'h00, 1'b0, 4'h0);
        op(16'h5f10, 8'h01, 1'b0, 4'h0);
        @(posedge i_mclk);
        i_instr_valid <= 1'b0;
        #1;
        post();
        complete_run();
    end
endmodule
